// File: rss_reset_sequencer.sv
// Reset source merger, cause recorder, release sequencer and boot fetch starter.
`timescale 1ns/1ps
`default_nettype none
`include "rss_map.svh"

module rss_reset_sequencer (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               clk_en,
  input  wire logic               hsel,
  input  wire logic [7:0]         haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic      [31:0]        hrdata,
  output logic                    hresp,
  input  wire logic               ext_reset_n,
  input  wire logic               por_detect,
  input  wire logic               brownout_detect,
  input  wire logic               watchdog_reset,
  input  wire logic               boot_ack,
  output logic                    core_reset_n,
  output logic      [7:0]         peripheral_reset_n,
  output logic                    tap_reset_n,
  output logic      [2:0]         boot_fetch,
  output logic                    core_run,
  output logic                    irq
);
  import rss_pkg::*;

  // --------------------------------------------------------------------------
  // State record.
  // --------------------------------------------------------------------------
  // Every flip-flop of the block lives in this one record.
  typedef struct packed {
    logic        pin_s1;      // Pin synchroniser, first stage.
    logic        pin_s2;      // Pin synchroniser, second stage.
    logic        por_s1;      // Power-on detector synchroniser, first stage.
    logic        por_s2;      // Power-on detector synchroniser, second stage.
    logic        bod_s1;      // Brown-out detector synchroniser, first stage.
    logic        bod_s2;      // Brown-out detector synchroniser, second stage.
    logic        bod_s3;      // Delayed second stage, so edge detection never reads the first stage.
    logic        por_done;    // Set once the first power-on pulse has ended.
    rss_state_t  state;       // Sequencer state.
    logic [3:0]  sync_cnt;    // Release synchronisation counter.
    logic [4:0]  cause;       // Sticky reset cause bits.
    logic        bor_en;      // Brown-out reset enable.
    logic        sys_req;     // Pending system reset request.
    logic [7:0]  prst;        // Peripheral reset control bits.
    logic [1:0]  irq_stat;    // Sticky interrupt status.
    logic [1:0]  irq_mask;    // Interrupt mask.
    logic        irq;         // Registered interrupt line.
    logic        core_rst_n;  // Core reset output.
    logic [7:0]  prst_n;      // Per-peripheral reset outputs.
    logic        tap_rst_n;   // Test port reset output.
    logic [2:0]  fetch;       // One-hot boot fetch stage.
    logic        run;         // Core released to execute.
    logic        ap_valid;    // A data phase is in progress.
    logic        ap_write;    // That data phase is a write.
    logic [7:0]  ap_addr;     // Address captured in the address phase.
    logic [31:0] rdata;       // Read data for the data phase.
  } rss_regs_t;

  rss_regs_t s;       // Current state.
  rss_regs_t next_s;  // Next state.

  // Decoded request levels, derived from synchronised or local signals and the raw watchdog_reset input.
  logic       ext_req;   // Pin held low.
  logic       por_req;   // First power-on still active.
  logic       bor_req;   // Enabled brown-out present.
  logic       any_req;   // Some source asks for reset.
  logic       wr_cause;  // Data-phase write to the cause register.
  logic [4:0] cause_set; // Cause bits raised this cycle.

  // --------------------------------------------------------------------------
  // Request decode.
  // --------------------------------------------------------------------------
  // Of the synchronisers only second stages feed this decode, never a first stage; watchdog_reset enters unsynchronised.
  always_comb begin
    ext_req   = !s.pin_s2;
    por_req   = s.por_s2 && !s.por_done;
    bor_req   = s.bod_s2 && s.bor_en;
    any_req   = ext_req || por_req || bor_req || s.sys_req || watchdog_reset;
    wr_cause  = s.ap_valid && s.ap_write && (s.ap_addr == `RSS_OFF_CAUSE);
    cause_set = 5'h00;
    cause_set[`RSS_CAUSE_EXT] = ext_req;
    cause_set[`RSS_CAUSE_BOR] = bor_req;
    cause_set[`RSS_CAUSE_SW]  = s.sys_req;
    cause_set[`RSS_CAUSE_WDT] = watchdog_reset;
  end

  // --------------------------------------------------------------------------
  // Next-state logic.
  // --------------------------------------------------------------------------
  always_comb begin
    next_s = s;

    // Two-stage synchronisers for the pin and the analog monitors.
    next_s.pin_s1 = ext_reset_n;
    next_s.pin_s2 = s.pin_s1;
    next_s.por_s1 = por_detect;
    next_s.por_s2 = s.por_s1;
    next_s.bod_s1 = brownout_detect;
    next_s.bod_s2 = s.bod_s1;
    next_s.bod_s3 = s.bod_s2;

    // Once the first power-on pulse ends, later detector glitches are ignored.
    if (!s.por_s2) begin
      next_s.por_done = 1'b1;
    end

    // Sequencer: any source forces hold, which is left only when all are gone.
    case (s.state)
      RSS_HOLD: begin
        if (!any_req) begin
          next_s.state    = RSS_SYNC;
          next_s.sync_cnt = 4'h0;
        end
      end
      RSS_SYNC: begin
        // Release waits a few clocks so every domain leaves reset on a clean edge.
        if (s.sync_cnt == `RSS_SYNC_CYCLES - 4'h1) begin
          next_s.state = RSS_FETCH_SP;
        end else begin
          next_s.sync_cnt = s.sync_cnt + 4'h1;
        end
      end
      RSS_FETCH_SP: begin
        if (boot_ack) begin
          next_s.state = RSS_FETCH_PC;
        end
      end
      RSS_FETCH_PC: begin
        if (boot_ack) begin
          next_s.state = RSS_FETCH_INSN;
        end
      end
      RSS_FETCH_INSN: begin
        if (boot_ack) begin
          next_s.state = RSS_RUN;
        end
      end
      RSS_RUN: begin
        next_s.state = RSS_RUN;
      end
      default: begin
        next_s.state = RSS_HOLD;
      end
    endcase
    // A new request overrides every state, so reset takes effect at once.
    if (any_req) begin
      next_s.state = RSS_HOLD;
    end

    // Output resets follow the next state, the test port reset follows por_req, so they are registered.
    next_s.core_rst_n = (next_s.state != RSS_HOLD) && (next_s.state != RSS_SYNC);
    next_s.prst_n     = {8{next_s.core_rst_n}} & ~s.prst;
    next_s.tap_rst_n  = !por_req;
    next_s.fetch[0]   = (next_s.state == RSS_FETCH_SP);
    next_s.fetch[1]   = (next_s.state == RSS_FETCH_PC);
    next_s.fetch[2]   = (next_s.state == RSS_FETCH_INSN);
    next_s.run        = (next_s.state == RSS_RUN);

    // The request is consumed once the sequencer holds reset for it.
    if (s.state == RSS_HOLD) begin
      next_s.sys_req = 1'b0;
    end

    // Cause bits: a set in the same cycle as a clear wins over the clear.
    if (wr_cause) begin
      next_s.cause = s.cause & ~hwdata[4:0];
    end
    next_s.cause = next_s.cause | cause_set;
    if (por_req) begin
      next_s.cause = `RSS_CAUSE_POR_ONLY;
    end

    // Interrupt status clears by writing ones; events win over the clear.
    if (s.ap_valid && s.ap_write && (s.ap_addr == `RSS_OFF_IRQ_STAT)) begin
      next_s.irq_stat = s.irq_stat & ~hwdata[1:0];
    end
    if (s.bod_s2 && !s.bod_s3) begin
      // Brown-out detector rising, useful even when reset is disabled.
      next_s.irq_stat[`RSS_IRQ_BROWNOUT] = 1'b1;
    end
    if (!s.run && next_s.run) begin
      next_s.irq_stat[`RSS_IRQ_BOOTED] = 1'b1;
    end

    // Register writes complete in the data phase with hwdata.
    if (s.ap_valid && s.ap_write) begin
      case (s.ap_addr)
        `RSS_OFF_CTRL: begin
          next_s.bor_en = hwdata[`RSS_CTRL_BOR_EN];
          if (hwdata[`RSS_CTRL_SYSREQ]) begin
            next_s.sys_req = 1'b1;
          end
        end
        `RSS_OFF_PRST: begin
          next_s.prst = hwdata[7:0];
        end
        `RSS_OFF_IRQ_MASK: begin
          next_s.irq_mask = hwdata[1:0];
        end
        default: begin
          next_s.prst = next_s.prst;
        end
      endcase
    end
    next_s.irq = |(next_s.irq_stat & next_s.irq_mask);

    // Address phase capture; the slave never inserts wait states.
    next_s.ap_valid = hsel && htrans[1] && hready;
    next_s.ap_write = hwrite;
    next_s.ap_addr  = haddr;
    next_s.rdata    = 32'h0000_0000;
    if (hsel && htrans[1] && hready && !hwrite) begin
      // Read data comes from the next values, but the state from the current one, so a write just before is seen.
      case (haddr)
        `RSS_OFF_CAUSE:    next_s.rdata[4:0] = next_s.cause;
        `RSS_OFF_CTRL:     next_s.rdata[1:0] = {next_s.sys_req, next_s.bor_en};
        `RSS_OFF_PRST:     next_s.rdata[7:0] = next_s.prst;
        `RSS_OFF_IRQ_STAT: next_s.rdata[1:0] = next_s.irq_stat;
        `RSS_OFF_IRQ_MASK: next_s.rdata[1:0] = next_s.irq_mask;
        `RSS_OFF_STATE:    next_s.rdata[2:0] = s.state;
        default:           next_s.rdata      = 32'h0000_0000;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // State register.
  // --------------------------------------------------------------------------
  // The power supply reset starts everything in hold with a power-on cause.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s            <= '0;
      s.por_s1     <= 1'b1;
      s.por_s2     <= 1'b1;
      s.state      <= RSS_HOLD;
      s.cause      <= `RSS_CAUSE_POR_ONLY;
      s.bor_en     <= 1'b0;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // Outputs straight from the state record, apart from the constant hreadyout and hresp.
  assign hreadyout          = 1'b1;
  assign hresp              = 1'b0;
  assign hrdata             = s.rdata;
  assign core_reset_n       = s.core_rst_n;
  assign peripheral_reset_n = s.prst_n;
  assign tap_reset_n        = s.tap_rst_n;
  assign boot_fetch         = s.fetch;
  assign core_run           = s.run;
  assign irq                = s.irq;

  // --------------------------------------------------------------------------
  // Assertions.
  // --------------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_any_source_resets;
    clk_en && any_req |=> !core_reset_n && (peripheral_reset_n == 8'h00);
  endproperty
  a_any_source_resets: assert property (p_any_source_resets)
    else $error("A reset source did not drive the internal reset.");

  property p_wdt_cause;
    clk_en && watchdog_reset && !por_req |=> s.cause[`RSS_CAUSE_WDT];
  endproperty
  a_wdt_cause: assert property (p_wdt_cause)
    else $error("Watchdog reset did not record its cause.");

  property p_cause_sticky;
    clk_en && !por_req && !wr_cause |=> ((s.cause & $past(s.cause)) == $past(s.cause));
  endproperty
  a_cause_sticky: assert property (p_cause_sticky)
    else $error("A reset cause bit was lost.");

  property p_por_only;
    clk_en && por_req |=> (s.cause == `RSS_CAUSE_POR_ONLY) && !tap_reset_n;
  endproperty
  a_por_only: assert property (p_por_only)
    else $error("Power-on did not leave only its cause bit.");

  property p_pin_spares_tap;
    clk_en && ext_req && !por_req |=> tap_reset_n && !core_reset_n;
  endproperty
  a_pin_spares_tap: assert property (p_pin_spares_tap)
    else $error("Pin reset touched the test port or missed the core.");

  property p_release_after_sync;
    $rose(core_reset_n) |-> ($past(s.state) == RSS_SYNC) && (boot_fetch == 3'h1);
  endproperty
  a_release_after_sync: assert property (p_release_after_sync)
    else $error("Internal reset released without synchronisation.");

  property p_boot_order;
    clk_en && boot_fetch[0] && boot_ack && !any_req |=> boot_fetch == 3'h2;
  endproperty
  a_boot_order: assert property (p_boot_order)
    else $error("Boot fetch did not move from stack to counter.");

  property p_bor_gated;
    clk_en && s.bod_s2 && !s.bor_en && !any_req && s.run |=> core_reset_n;
  endproperty
  a_bor_gated: assert property (p_bor_gated)
    else $error("Disabled brown-out caused a reset.");

  property p_cause_clear;
    clk_en && wr_cause && hwdata[`RSS_CAUSE_SW] && !s.sys_req && !por_req
      |=> !s.cause[`RSS_CAUSE_SW];
  endproperty
  a_cause_clear: assert property (p_cause_clear)
    else $error("Writing one did not clear a cause bit.");

  c_pin_boot: cover property ($rose(core_run));
  c_sw_reset: cover property (clk_en && s.sys_req ##1 !core_reset_n);
  c_bor_reset: cover property (clk_en && bor_req ##1 s.cause[`RSS_CAUSE_BOR]);

endmodule
`default_nettype wire

// File: rss_map.svh
// Register offsets, field positions, reset values and timing counts of the reset sequencer.
`ifndef RSS_MAP_SVH
`define RSS_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------------------
`define RSS_OFF_CAUSE     8'h00
`define RSS_OFF_CTRL      8'h04
`define RSS_OFF_PRST      8'h08
`define RSS_OFF_IRQ_STAT  8'h0c
`define RSS_OFF_IRQ_MASK  8'h10
`define RSS_OFF_STATE     8'h14

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define RSS_CAUSE_EXT     0
`define RSS_CAUSE_POR     1
`define RSS_CAUSE_BOR     2
`define RSS_CAUSE_SW      3
`define RSS_CAUSE_WDT     4
`define RSS_CTRL_BOR_EN   0
`define RSS_CTRL_SYSREQ   1
`define RSS_IRQ_BROWNOUT  0
`define RSS_IRQ_BOOTED    1

// ----------------------------------------------------------------------------
// Reset values and timing.
// ----------------------------------------------------------------------------
`define RSS_CAUSE_POR_ONLY 5'h02
`define RSS_SYNC_CYCLES    4'h4

`endif

// File: rss_pkg.sv
// Types shared by the reset sequencer.
package rss_pkg;

  // Sequencer states, from held reset to running code.
  typedef enum logic [2:0] {
    RSS_HOLD,
    RSS_SYNC,
    RSS_FETCH_SP,
    RSS_FETCH_PC,
    RSS_FETCH_INSN,
    RSS_RUN
  } rss_state_t;

endpackage

// File: rss_supply_model.sv
// Behavioural model of the reset pin circuitry and the supply monitors.
`timescale 1ns/1ps
`default_nettype none

module rss_supply_model #(
  parameter int POR_LEN = 20
) (
  input  wire logic hclk,
  input  wire logic pin_req,
  input  wire logic bo_req,
  input  wire logic por_req,
  output logic      ext_reset_n,
  output logic      por_detect,
  output logic      brownout_detect
);
  int unsigned age = 0;  // Cycles since power was applied, held once it reaches POR_LEN.

  // ---------------------------------------------------------------------------
  // Power-on detector.
  // ---------------------------------------------------------------------------
  // The detector pulses once at power-up; por_req lets the bench fake a glitch.
  always @(posedge hclk) begin
    if (age < POR_LEN) begin
      age <= age + 1;
    end
  end
  assign por_detect = (age < POR_LEN) | por_req;

  // The pin has a pull-up, so it reads high whenever nobody pulls it down.
  assign ext_reset_n     = ~pin_req;
  assign brownout_detect = bo_req;
endmodule

`default_nettype wire

// File: tb_reset_source_sequencer.sv
// Self-checking bench of the reset source sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "rss_map.svh"

module tb_reset_source_sequencer;
  import rss_pkg::*;
  typedef struct { logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] q; } rss_row_t;

  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, q;
  logic        hreadyout, hresp, ext_reset_n, por_detect, brownout_detect;
  logic        core_reset_n, tap_reset_n, core_run, irq;
  logic        boot_ack = 1'b0, watchdog_reset = 1'b0, clk_en = 1'b1;
  logic        pin_req = 1'b1, bo_req = 1'b0, por_req = 1'b0;
  logic [7:0]  peripheral_reset_n;
  logic [2:0]  boot_fetch;
  int          failures = 0, check_count = 0;

  // Ordinary register cases: write (when wr) then read back.
  rss_row_t rows [9] = '{
    '{1'b0, `RSS_OFF_CAUSE, 32'h0, 32'h02},
    '{1'b0, `RSS_OFF_STATE, 32'h0, 32'h05},
    '{1'b0, `RSS_OFF_IRQ_STAT, 32'h0, 32'h02},
    '{1'b1, `RSS_OFF_PRST, 32'h5a, 32'h5a},
    '{1'b1, `RSS_OFF_PRST, 32'h0, 32'h0},
    '{1'b1, `RSS_OFF_IRQ_MASK, 32'h3, 32'h3},
    '{1'b1, `RSS_OFF_IRQ_STAT, 32'h2, 32'h0},
    '{1'b1, 8'h18, 32'hffffffff, 32'h0},
    '{1'b1, `RSS_OFF_CTRL, 32'h0, 32'h0}
  };

  always #2.5 hclk = ~hclk;

  rss_supply_model model (.hclk, .pin_req, .bo_req, .por_req, .ext_reset_n, .por_detect, .brownout_detect);

  // The only slave's ready is the bus ready; word transfers only.
  rss_reset_sequencer dut (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .ext_reset_n, .por_detect, .brownout_detect,
    .watchdog_reset, .boot_ack, .core_reset_n, .peripheral_reset_n, .tap_reset_n, .boot_fetch, .core_run, .irq);

  // ---------------------------------------------------------------------------
  // Checking and bus tasks.
  // ---------------------------------------------------------------------------
  task automatic test_done;
    if (failures == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic timeout;
    failures++;
    $display("mismatch at %0t: wait timed out", $time);
    test_done();
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  // Ends just after a rising edge at which hready was high.
  task automatic ready_edge;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) timeout();
  endtask

  // Read data is taken at the edge ending the data phase, before it moves on.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    ready_edge();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    ready_edge();
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk_word(q, e);
    chk_bit(hresp, 1'b0);
  endtask

  // Counts edges until the core leaves reset; the count shows the release delay.
  task automatic wait_core(output int n);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (core_reset_n !== 1'b1 && n < 300);
    if (core_reset_n !== 1'b1) timeout();
  endtask

  // Acknowledges each fetch stage in turn and expects the core to run after.
  task automatic boot;
    for (int i = 0; i < 3; i++) begin
      chk_word({29'h0, boot_fetch}, 32'h1 << i);
      boot_ack <= 1'b1;
      @(posedge hclk);
      boot_ack <= 1'b0;
      @(posedge hclk);
    end
    chk_bit(core_run, 1'b1);
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------------------
  initial begin
    int n;
    repeat (8) @(posedge hclk);
    chk_bit(core_reset_n, 1'b0);
    chk_word({24'h0, peripheral_reset_n}, 32'h0);
    chk_bit(tap_reset_n, 1'b0);
    chk_bit(irq, 1'b0);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    pin_req <= 1'b0;
    // The pin is gone but power-on still holds the part in reset.
    repeat (6) @(posedge hclk);
    chk_bit(core_reset_n, 1'b0);
    wait_core(n);
    chk_bit(tap_reset_n, 1'b1);
    boot();
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].q);
    end
    // A peripheral bit set then cleared pulses only its own reset line.
    wr(`RSS_OFF_PRST, 32'h04);
    repeat (2) @(posedge hclk);
    chk_word({24'h0, peripheral_reset_n}, 32'hfb);
    wr(`RSS_OFF_PRST, 32'h00);
    repeat (2) @(posedge hclk);
    chk_word({24'h0, peripheral_reset_n}, 32'hff);
    // Pin reset: core and peripherals reset, test port left alone.
    pin_req <= 1'b1;
    repeat (10) @(posedge hclk);
    chk_bit(core_reset_n, 1'b0);
    chk_word({24'h0, peripheral_reset_n}, 32'h0);
    chk_bit(tap_reset_n, 1'b1);
    pin_req <= 1'b0;
    wait_core(n);
    chk_bit(n >= `RSS_SYNC_CYCLES, 1'b1);
    boot();
    rd(`RSS_OFF_CAUSE, 32'h03);
    // A single watchdog cycle is enough to reset.
    watchdog_reset <= 1'b1;
    @(posedge hclk);
    watchdog_reset <= 1'b0;
    repeat (3) @(posedge hclk);
    chk_bit(core_reset_n, 1'b0);
    wait_core(n);
    boot();
    rd(`RSS_OFF_CAUSE, 32'h13);
    // Software system reset request, which must clear itself.
    wr(`RSS_OFF_CTRL, 32'h02);
    repeat (3) @(posedge hclk);
    chk_bit(core_reset_n, 1'b0);
    wait_core(n);
    boot();
    rd(`RSS_OFF_CAUSE, 32'h1b);
    rd(`RSS_OFF_CTRL, 32'h0);
    // Brown-out while disabled only raises its interrupt.
    bo_req <= 1'b1;
    repeat (8) @(posedge hclk);
    chk_bit(core_reset_n, 1'b1);
    bo_req <= 1'b0;
    wr(`RSS_OFF_IRQ_MASK, 32'h1);
    rd(`RSS_OFF_IRQ_STAT, 32'h3);
    chk_bit(irq, 1'b1);
    wr(`RSS_OFF_IRQ_MASK, 32'h0);
    repeat (2) @(posedge hclk);
    chk_bit(irq, 1'b0);
    wr(`RSS_OFF_IRQ_STAT, 32'h3);
    wr(`RSS_OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge hclk);
    chk_bit(irq, 1'b0);
    // Enabled brown-out holds reset for as long as the supply is low.
    wr(`RSS_OFF_CTRL, 32'h01);
    bo_req <= 1'b1;
    repeat (30) @(posedge hclk);
    chk_bit(core_reset_n, 1'b0);
    bo_req <= 1'b0;
    wait_core(n);
    boot();
    rd(`RSS_OFF_CAUSE, 32'h1f);
    wr(`RSS_OFF_CAUSE, 32'h1f);
    rd(`RSS_OFF_CAUSE, 32'h0);
    // A later power-on pulse while powered must be ignored.
    por_req <= 1'b1;
    repeat (10) @(posedge hclk);
    por_req <= 1'b0;
    repeat (6) @(posedge hclk);
    chk_bit(core_reset_n, 1'b1);
    chk_bit(tap_reset_n, 1'b1);
    rd(`RSS_OFF_CAUSE, 32'h0);
    // A low clock enable freezes the block, so a watchdog pulse meanwhile is never seen.
    clk_en         <= 1'b0;
    watchdog_reset <= 1'b1;
    repeat (3) @(posedge hclk);
    watchdog_reset <= 1'b0;
    repeat (2) @(posedge hclk);
    clk_en         <= 1'b1;
    repeat (3) @(posedge hclk);
    chk_bit(core_reset_n, 1'b1);
    rd(`RSS_OFF_CAUSE, 32'h0);
    test_done();
  end
endmodule

`default_nettype wire
